// ===== src/nace_pkg.sv
// Constants for the nibble arithmetic and compare executor
`default_nettype none

package nace_pkg;

   // Instruction word layout
   localparam int OP_MSB  = 15;
   localparam int OP_LSB  = 10;
   localparam int ROW_MSB = 9;
   localparam int ROW_LSB = 8;
   localparam int COL_MSB = 7;
   localparam int COL_LSB = 4;
   localparam int IDX_MSB = 3;
   localparam int IDX_LSB = 0;

   // Register operands live at the bottom of bank 0
   localparam logic [3:0] REG_BASE = 4'h0;

   // Register add group
   localparam logic [5:0] SUM_REG_MEM          = 6'h10;
   localparam logic [5:0] SUM_REG_MEM_SKIP     = 6'h11;
   localparam logic [5:0] SUM_REG_MEM_CIN      = 6'h12;
   localparam logic [5:0] SUM_REG_MEM_CIN_SKIP = 6'h13;
   // Immediate add group
   localparam logic [5:0] IMM_PLUS_MEM          = 6'h14;
   localparam logic [5:0] IMM_PLUS_MEM_SKIP     = 6'h15;
   localparam logic [5:0] IMM_PLUS_MEM_CIN      = 6'h16;
   localparam logic [5:0] IMM_PLUS_MEM_CIN_SKIP = 6'h17;
   // Register subtract group
   localparam logic [5:0] REG_MINUS_MEM          = 6'h18;
   localparam logic [5:0] REG_MINUS_MEM_SKIP     = 6'h19;
   localparam logic [5:0] REG_MINUS_MEM_BIN      = 6'h1A;
   localparam logic [5:0] REG_MINUS_MEM_BIN_SKIP = 6'h1B;
   // Immediate subtract group
   localparam logic [5:0] MEM_MINUS_IMM          = 6'h1C;
   localparam logic [5:0] MEM_MINUS_IMM_SKIP     = 6'h1D;
   localparam logic [5:0] MEM_MINUS_IMM_BIN      = 6'h1E;
   localparam logic [5:0] MEM_MINUS_IMM_BIN_SKIP = 6'h1F;
   // Compares
   localparam logic [5:0] REG_EQ_MEM_SKIP = 6'h01;
   localparam logic [5:0] REG_GE_MEM_SKIP = 6'h03;
   localparam logic [5:0] MEM_EQ_IMM_SKIP = 6'h0D;
   localparam logic [5:0] MEM_GE_IMM_SKIP = 6'h0F;

   // Values after reset
   localparam logic       CARRY_RST = 1'b0;
   localparam logic       SKIP_RST  = 1'b0;
   localparam logic       READY_RST = 1'b1;

   // Sequencer states
   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_RD_MEM = 4'b0010,
      ST_RD_REG = 4'b0100,
      ST_EXEC   = 4'b1000
   } nace_state_e;

endpackage

`default_nettype wire

// ===== src/nace_nibble_alu.sv
// Nibble adder and subtractor with carry or borrow in and out
`default_nettype none

module nace_nibble_alu #(
   parameter int W = 4
) (
   input  wire logic [W-1:0] i_a,
   input  wire logic [W-1:0] i_b,
   input  wire logic         i_sub,
   input  wire logic         i_cin,
   output logic      [W-1:0] o_res,
   output logic              o_cout,
   output logic              o_zero
);

   logic [W:0] ext_a;
   logic [W:0] ext_b;
   logic [W:0] ext_c;
   logic [W:0] sum;

   // Widen by one bit so the top bit is carry out or borrow
   assign ext_a  = {1'b0, i_a};
   assign ext_b  = {1'b0, i_b};
   assign ext_c  = {{W{1'b0}}, i_cin};
   assign sum    = i_sub ? (ext_a - ext_b - ext_c) : (ext_a + ext_b + ext_c);
   assign o_res  = sum[W-1:0];
   assign o_cout = sum[W];
   assign o_zero = (sum[W-1:0] == {W{1'b0}});

endmodule

`default_nettype wire

// ===== src/nace_exec.sv
// Decoder and executor for nibble arithmetic and compare instructions
`default_nettype none

module nace_exec #(
   parameter int DW = 4,
   parameter int AW = 8
) (
   input  wire logic          i_ref_clk,
   input  wire logic          i_reset,
   input  wire logic          i_instr_valid,
   input  wire logic [15:0]   i_instr,
   input  wire logic [1:0]    i_bank,
   input  wire logic [DW-1:0] i_ram_rdata,
   output logic               o_ready,
   output logic      [AW-1:0] o_ram_addr,
   output logic               o_ram_rd,
   output logic               o_ram_wr,
   output logic      [DW-1:0] o_ram_wdata,
   output logic               o_done,
   output logic               o_skip,
   output logic               o_carry,
   output logic               o_unsupported
);

   nace_pkg::nace_state_e state;
   nace_pkg::nace_state_e next_state;

   logic [15:0]   instr_q;
   logic [DW-1:0] mem_q;
   logic [AW-1:0] mem_addr_q;
   logic [15:0]   next_instr;
   logic [DW-1:0] next_mem;
   logic [AW-1:0] next_mem_addr;
   logic [AW-1:0] next_ram_addr;
   logic          next_ram_rd;
   logic          next_ram_wr;
   logic [DW-1:0] next_ram_wdata;
   logic          next_done;
   logic          next_skip;
   logic          next_carry;
   logic          next_unsupported;

   wire           in_idle;
   wire           accept;
   wire    [15:0] dec_word;
   wire     [5:0] op;
   wire     [1:0] row;
   wire     [3:0] col;
   wire     [3:0] idx;
   wire  [AW-1:0] mem_addr;
   wire  [AW-1:0] reg_addr;

   wire           add_reg;
   wire           add_imm;
   wire           sub_reg;
   wire           sub_imm;
   wire           eq_reg;
   wire           ge_reg;
   wire           eq_imm;
   wire           ge_imm;
   wire           arith;
   wire           uses_reg;
   wire           supported;
   wire           uses_flag;
   wire           skip_form;

   wire  [DW-1:0] alu_b;
   wire           alu_sub;
   wire           alu_cin;
   wire  [DW-1:0] alu_res;
   wire           alu_cout;
   wire           alu_zero;
   wire           skip_hit;

   // Incoming word is decoded while idle, the held word afterwards
   assign in_idle  = (state == nace_pkg::ST_IDLE);
   assign accept   = in_idle & i_instr_valid;
   assign dec_word = in_idle ? i_instr : instr_q;

   // Field split of the word
   assign op  = dec_word[nace_pkg::OP_MSB:nace_pkg::OP_LSB];
   assign row = dec_word[nace_pkg::ROW_MSB:nace_pkg::ROW_LSB];
   assign col = dec_word[nace_pkg::COL_MSB:nace_pkg::COL_LSB];
   assign idx = dec_word[nace_pkg::IDX_MSB:nace_pkg::IDX_LSB];

   // Operand addresses; register ignores the current bank
   assign mem_addr = {i_bank, row, col};
   assign reg_addr = {nace_pkg::REG_BASE, idx};

   // Register add group
   assign add_reg = (op == nace_pkg::SUM_REG_MEM)
                  | (op == nace_pkg::SUM_REG_MEM_SKIP)
                  | (op == nace_pkg::SUM_REG_MEM_CIN)
                  | (op == nace_pkg::SUM_REG_MEM_CIN_SKIP);

   // Immediate add group
   assign add_imm = (op == nace_pkg::IMM_PLUS_MEM)
                  | (op == nace_pkg::IMM_PLUS_MEM_SKIP)
                  | (op == nace_pkg::IMM_PLUS_MEM_CIN)
                  | (op == nace_pkg::IMM_PLUS_MEM_CIN_SKIP);

   // Register subtract group
   assign sub_reg = (op == nace_pkg::REG_MINUS_MEM)
                  | (op == nace_pkg::REG_MINUS_MEM_SKIP)
                  | (op == nace_pkg::REG_MINUS_MEM_BIN)
                  | (op == nace_pkg::REG_MINUS_MEM_BIN_SKIP);

   // Immediate subtract group
   assign sub_imm = (op == nace_pkg::MEM_MINUS_IMM)
                  | (op == nace_pkg::MEM_MINUS_IMM_SKIP)
                  | (op == nace_pkg::MEM_MINUS_IMM_BIN)
                  | (op == nace_pkg::MEM_MINUS_IMM_BIN_SKIP);

   // Compares
   assign eq_reg = (op == nace_pkg::REG_EQ_MEM_SKIP);
   assign ge_reg = (op == nace_pkg::REG_GE_MEM_SKIP);
   assign eq_imm = (op == nace_pkg::MEM_EQ_IMM_SKIP);
   assign ge_imm = (op == nace_pkg::MEM_GE_IMM_SKIP);

   // Class of the decoded word
   assign arith     = add_reg | add_imm | sub_reg | sub_imm;
   assign uses_reg  = add_reg | sub_reg | eq_reg | ge_reg;
   assign supported = arith | eq_reg | ge_reg | eq_imm | ge_imm;

   // Low opcode bits: bit 1 takes the flag, bit 0 asks for a skip
   assign uses_flag = arith & op[1];
   assign skip_form = arith & op[0];

   // Second operand is the held memory nibble or the immediate
   assign alu_b   = uses_reg ? mem_q : idx;
   assign alu_sub = sub_reg | sub_imm | eq_reg | ge_reg | eq_imm | ge_imm;
   assign alu_cin = uses_flag ? o_carry : 1'b0;

   // Skip decision for the executing word
   assign skip_hit = (skip_form & alu_cout)
                   | ((eq_reg | eq_imm) & alu_zero)
                   | ((ge_reg | ge_imm) & ~alu_cout);

   // Nibble arithmetic; first operand is whatever the RAM returns now
   nace_nibble_alu #(
      .W      (DW)
   ) u_alu (
      .i_a    (i_ram_rdata),
      .i_b    (alu_b),
      .i_sub  (alu_sub),
      .i_cin  (alu_cin),
      .o_res  (alu_res),
      .o_cout (alu_cout),
      .o_zero (alu_zero)
   );

   // Next state and next output values
   always_comb begin
      next_state       = state;
      next_instr       = instr_q;
      next_mem         = mem_q;
      next_mem_addr    = mem_addr_q;
      next_ram_addr    = o_ram_addr;
      next_ram_rd      = 1'b0;
      next_ram_wr      = 1'b0;
      next_ram_wdata   = o_ram_wdata;
      next_done        = 1'b0;
      next_skip        = o_skip;
      next_carry       = o_carry;
      next_unsupported = 1'b0;
      case (state)
         nace_pkg::ST_IDLE: begin
            if (accept) begin
               next_instr = i_instr;
               if (o_skip) begin
                  // Discarded word: one cycle, only the held word, skip and done move
                  next_skip = 1'b0;
                  next_done = 1'b1;
               end else if (supported) begin
                  next_mem_addr = mem_addr;
                  next_ram_addr = mem_addr;
                  next_ram_rd   = 1'b1;
                  next_state    = nace_pkg::ST_RD_MEM;
               end else begin
                  next_done        = 1'b1;
                  next_unsupported = 1'b1;
               end
            end
         end
         nace_pkg::ST_RD_MEM: begin
            if (uses_reg) begin
               next_ram_addr = reg_addr;
               next_ram_rd   = 1'b1;
               next_state    = nace_pkg::ST_RD_REG;
            end else begin
               next_state = nace_pkg::ST_EXEC;
            end
         end
         nace_pkg::ST_RD_REG: begin
            next_mem   = i_ram_rdata;
            next_state = nace_pkg::ST_EXEC;
         end
         nace_pkg::ST_EXEC: begin
            if (arith) begin
               // Register forms write back to the register, others to memory
               next_ram_addr  = uses_reg ? reg_addr : mem_addr_q;
               next_ram_wdata = alu_res;
               next_ram_wr    = 1'b1;
               next_carry     = alu_cout;
            end
            next_skip  = skip_hit;
            next_done  = 1'b1;
            next_state = nace_pkg::ST_IDLE;
         end
         default: begin
            next_state = nace_pkg::ST_IDLE;
         end
      endcase
   end

   // Sequencer state and held operands
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         state      <= nace_pkg::ST_IDLE;
         instr_q    <= 16'h0000;
         mem_q      <= {DW{1'b0}};
         mem_addr_q <= {AW{1'b0}};
      end else begin
         state      <= next_state;
         instr_q    <= next_instr;
         mem_q      <= next_mem;
         mem_addr_q <= next_mem_addr;
      end
   end

   // RAM port outputs
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_ram_addr  <= {AW{1'b0}};
         o_ram_rd    <= 1'b0;
         o_ram_wr    <= 1'b0;
         o_ram_wdata <= {DW{1'b0}};
      end else begin
         o_ram_addr  <= next_ram_addr;
         o_ram_rd    <= next_ram_rd;
         o_ram_wr    <= next_ram_wr;
         o_ram_wdata <= next_ram_wdata;
      end
   end

   // Sequencer handshake, skip and flag outputs
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_ready       <= nace_pkg::READY_RST;
         o_done        <= 1'b0;
         o_skip        <= nace_pkg::SKIP_RST;
         o_carry       <= nace_pkg::CARRY_RST;
         o_unsupported <= 1'b0;
      end else begin
         o_ready       <= (next_state == nace_pkg::ST_IDLE);
         o_done        <= next_done;
         o_skip        <= next_skip;
         o_carry       <= next_carry;
         o_unsupported <= next_unsupported;
      end
   end

endmodule

`default_nettype wire

// ===== verif/nace_exec_asserts.sv
// Port checker for the nibble arithmetic and compare executor
`default_nettype none

module nace_exec_asserts #(
   parameter int DW = 4,
   parameter int AW = 8
) (
   input wire logic          i_ref_clk,
   input wire logic          i_reset,
   input wire logic          i_instr_valid,
   input wire logic [15:0]   i_instr,
   input wire logic [1:0]    i_bank,
   input wire logic [DW-1:0] i_ram_rdata,
   input wire logic          o_ready,
   input wire logic [AW-1:0] o_ram_addr,
   input wire logic          o_ram_rd,
   input wire logic          o_ram_wr,
   input wire logic [DW-1:0] o_ram_wdata,
   input wire logic          o_done,
   input wire logic          o_skip,
   input wire logic          o_carry,
   input wire logic          o_unsupported
);
   logic        acc;
   logic        hit;
   logic [15:0] word_q;
   logic [1:0]  bank_q;

   // Accepted word, and accepted arithmetic word that is not discarded
   assign acc = o_ready && i_instr_valid;
   assign hit = acc && !o_skip && (i_instr[15:14] == 2'h1);

   // Word and bank of the last accepted instruction
   always_ff @(posedge i_ref_clk) begin
      if (acc) begin
         word_q <= i_instr;
         bank_q <= i_bank;
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);

   rst_idle_a: assert property (disable iff (1'b0) i_reset |=>
      o_ready && !o_skip && !o_carry && !o_done) else $error("reset state wrong");
   done_ready_a: assert property (o_done |-> o_ready) else $error("done without ready");
   unsup_nop_a: assert property (o_unsupported |-> o_done && !o_ram_wr)
      else $error("unsupported word acted");
   skip_word_a: assert property (acc && o_skip |=>
      o_done && !o_skip && !o_ram_rd && !o_ram_wr) else $error("skipped word acted");
   imm_time_a: assert property (hit && i_instr[12] |=>
      o_ram_rd && !o_ready ##1 !o_done ##1 o_done && o_ram_wr) else $error("imm op timing");
   reg_time_a: assert property (hit && !i_instr[12] |=> o_ram_rd
      ##1 o_ram_rd && o_ram_addr == {4'h0, word_q[3:0]} ##1 !o_ram_rd && !o_done
      ##1 o_done && o_ram_wr) else $error("reg op timing");
   mem_addr_a: assert property (hit |=> o_ram_addr == {bank_q, word_q[9:4]})
      else $error("memory address wrong");
   wr_addr_a: assert property (o_ram_wr |-> o_ram_addr ==
      (word_q[12] ? {bank_q, word_q[9:4]} : {4'h0, word_q[3:0]})) else $error("write address");
   cmp_nowr_a: assert property (o_done && word_q[15:14] == 2'h0 |-> !o_ram_wr)
      else $error("compare wrote");
   carry_chg_a: assert property ($changed(o_carry) && !$past(i_reset) |->
      o_done && o_ram_wr) else $error("carry moved outside add or sub");
   skip_set_a: assert property ($rose(o_skip) |-> o_done) else $error("skip set early");

   // Main scenarios
   cover property (acc && o_skip);
   cover property (o_unsupported);
   cover property ($rose(o_carry));
endmodule

bind nace_exec nace_exec_asserts #(.DW(DW), .AW(AW)) i_nace_exec_asserts (
   .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_instr_valid(i_instr_valid),
   .i_instr(i_instr), .i_bank(i_bank), .i_ram_rdata(i_ram_rdata), .o_ready(o_ready),
   .o_ram_addr(o_ram_addr), .o_ram_rd(o_ram_rd), .o_ram_wr(o_ram_wr),
   .o_ram_wdata(o_ram_wdata), .o_done(o_done), .o_skip(o_skip), .o_carry(o_carry),
   .o_unsupported(o_unsupported));

`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the nibble arithmetic and compare executor
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [5:0] op;
      logic [3:0] rv;
      logic [3:0] mv;
      logic [3:0] im;
      logic [3:0] res;
      logic       c;
      logic       s;
   } nace_row_s;

   logic        i_ref_clk;
   logic        i_reset;
   logic        i_instr_valid;
   logic [15:0] i_instr;
   logic [1:0]  i_bank;
   logic [3:0]  i_ram_rdata;
   logic        o_ready;
   logic [7:0]  o_ram_addr;
   logic        o_ram_rd;
   logic        o_ram_wr;
   logic [3:0]  o_ram_wdata;
   logic        o_done;
   logic        o_skip;
   logic        o_carry;
   logic        o_unsupported;
   logic [3:0]  mem [256];
   int          mismatches;
   int          n_compared;

   // Rows run in order: each carry-in is the flag left by the row above
   nace_row_s rows [27] = '{
      '{6'h10,4'h9,4'h8,4'h0,4'h1,1'h1,1'h0}, '{6'h03,4'h9,4'h2,4'h0,4'h9,1'h1,1'h1},
      '{6'h12,4'h2,4'h3,4'h0,4'h6,1'h0,1'h0}, '{6'h11,4'hF,4'h1,4'h0,4'h0,1'h1,1'h1},
      '{6'h13,4'h7,4'h8,4'h0,4'h0,1'h1,1'h1}, '{6'h16,4'h0,4'hE,4'h1,4'h0,1'h1,1'h0},
      '{6'h17,4'h0,4'h8,4'h7,4'h0,1'h1,1'h1}, '{6'h14,4'h0,4'hA,4'h5,4'hF,1'h0,1'h0},
      '{6'h15,4'h0,4'h3,4'hD,4'h0,1'h1,1'h1}, '{6'h18,4'h2,4'h5,4'h0,4'hD,1'h1,1'h0},
      '{6'h1A,4'h5,4'h2,4'h0,4'h2,1'h0,1'h0}, '{6'h19,4'h1,4'h2,4'h0,4'hF,1'h1,1'h1},
      '{6'h1B,4'h3,4'h3,4'h0,4'hF,1'h1,1'h1}, '{6'h1C,4'h0,4'h9,4'h3,4'h6,1'h0,1'h0},
      '{6'h1D,4'h0,4'h0,4'h1,4'hF,1'h1,1'h1}, '{6'h1F,4'h0,4'h2,4'h2,4'hF,1'h1,1'h1},
      '{6'h1E,4'h0,4'h8,4'h2,4'h5,1'h0,1'h0}, '{6'h1F,4'h0,4'h2,4'h2,4'h0,1'h0,1'h0},
      '{6'h1D,4'h0,4'h5,4'h5,4'h0,1'h0,1'h0}, '{6'h01,4'h4,4'h4,4'h0,4'h4,1'h0,1'h1},
      '{6'h01,4'h4,4'h5,4'h0,4'h4,1'h0,1'h0}, '{6'h03,4'h5,4'h5,4'h0,4'h5,1'h0,1'h1},
      '{6'h03,4'h4,4'h5,4'h0,4'h4,1'h0,1'h0}, '{6'h0D,4'h0,4'h7,4'h7,4'h7,1'h0,1'h1},
      '{6'h0D,4'h0,4'h7,4'h6,4'h7,1'h0,1'h0}, '{6'h0F,4'h0,4'h6,4'h7,4'h6,1'h0,1'h0},
      '{6'h0F,4'h0,4'h7,4'h7,4'h7,1'h0,1'h1}};

   nace_exec i_nace_exec (
      .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_instr_valid(i_instr_valid),
      .i_instr(i_instr), .i_bank(i_bank), .i_ram_rdata(i_ram_rdata), .o_ready(o_ready),
      .o_ram_addr(o_ram_addr), .o_ram_rd(o_ram_rd), .o_ram_wr(o_ram_wr),
      .o_ram_wdata(o_ram_wdata), .o_done(o_done), .o_skip(o_skip), .o_carry(o_carry),
      .o_unsupported(o_unsupported));

   // 50 MHz clock
   initial begin
      i_ref_clk = 1'b0;
      forever #10 i_ref_clk = ~i_ref_clk;
   end

   // Synchronous RAM, one cycle read latency; data scrambles when not read
   always @(posedge i_ref_clk) begin
      if (o_ram_wr) mem[o_ram_addr] <= o_ram_wdata;
      if (i_reset) i_ram_rdata <= 4'h0;
      else i_ram_rdata <= o_ram_rd ? mem[o_ram_addr] : ~i_ram_rdata;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One word: register at 03, memory at row 1 column 5 of the current bank,
   // decoy at nibble 03 of that bank; the bank is never 0 here
   task automatic run(input logic [5:0] op, input logic [3:0] rv, mv, im, res,
                      input logic c, s, input int lat, input logic u);
      int n;
      logic [7:0] ma;
      logic [7:0] da;
      ma = {i_bank, 6'h15};
      da = {i_bank, 6'h03};
      mem[ma] = mv;
      mem[8'h03] = rv;
      mem[da] = ~rv;
      @(negedge i_ref_clk);
      i_instr = {op, 2'h1, 4'h5, op[2] ? im : 4'h3};
      i_instr_valid = 1'b1;
      @(negedge i_ref_clk);
      i_instr_valid = 1'b0;
      n = 1;
      while (o_done !== 1'b1 && n < 12) begin
         @(negedge i_ref_clk);
         n++;
      end
      chk(8'(n), 8'(lat));
      chk(8'(o_unsupported), 8'(u));
      chk(8'(o_skip), 8'(s));
      chk(8'(o_carry), 8'(c));
      @(negedge i_ref_clk);
      chk(8'(op[2] ? mem[ma] : mem[8'h03]), 8'(res));
      chk(8'(op[2] ? mem[8'h03] : mem[ma]), 8'(op[2] ? rv : mv));
      chk(8'(mem[da] ^ rv), 8'h0F);
   endtask

   task automatic print_verdict();
      $display("compared %0d, mismatched %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (4000) @(posedge i_ref_clk);
      mismatches++;
      print_verdict();
   end

   initial begin
      i_reset = 1'b1;
      i_instr_valid = 1'b0;
      i_instr = 16'h0000;
      i_bank = 2'h2;
      i_ram_rdata = 4'h0;
      mismatches = 0;
      n_compared = 0;
      repeat (10) @(negedge i_ref_clk);
      i_reset = 1'b0;
      chk(8'({o_ready, o_carry, o_skip, o_done}), 8'h08);
      $display("reset test finished");
      // Table rows; a taken skip is followed by a word that must be discarded
      foreach (rows[k]) begin
         run(rows[k].op, rows[k].rv, rows[k].mv, rows[k].im, rows[k].res, rows[k].c,
             rows[k].s, rows[k].op[2] ? 3 : 4, 1'b0);
         if (rows[k].s) run(6'h14, 4'h0, 4'h5, 4'h1, 4'h5, rows[k].c, 1'b0, 1, 1'b0);
         $display("row %0d finished", k);
      end
      // Another bank from here on: memory operand follows it, register does not
      i_bank = 2'h1;
      // Reset while carry and skip are pending clears both
      run(6'h11, 4'hF, 4'h1, 4'h0, 4'h0, 1'b1, 1'b1, 4, 1'b0);
      i_reset = 1'b1;
      repeat (2) @(negedge i_ref_clk);
      i_reset = 1'b0;
      chk(8'({o_ready, o_carry, o_skip}), 8'h04);
      run(6'h10, 4'h1, 4'h2, 4'h0, 4'h3, 1'b0, 1'b0, 4, 1'b0);
      $display("mid-run reset finished");
      // Codes outside the handled set change nothing
      run(6'h08, 4'h1, 4'h2, 4'h0, 4'h1, 1'b0, 1'b0, 1, 1'b1);
      run(6'h02, 4'h1, 4'h2, 4'h0, 4'h1, 1'b0, 1'b0, 1, 1'b1);
      $display("unsupported codes finished");
      print_verdict();
   end
endmodule

`default_nettype wire
